// ==== flow_ctl_consts.vh ====
// register offsets, field positions, reset values and timing counts for the flow control block
`ifndef FLOW_CTL_CONSTS_VH
`define FLOW_CTL_CONSTS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define OFS_DIVISOR_LOW     8'h00
`define OFS_DIVISOR_HIGH    8'h04
`define OFS_DIVISOR_FRAC    8'h08
`define OFS_INT_ENABLE      8'h0C
`define OFS_INT_SOURCE      8'h10
`define OFS_FIFO_CTL        8'h14
`define OFS_LINE_CTL        8'h18
`define OFS_MODEM_CTL       8'h1C
`define OFS_LINE_STATUS     8'h20
`define OFS_MODEM_STATUS    8'h24
`define OFS_SCRATCH         8'h28
`define OFS_FEATURE_CTL     8'h2C
`define OFS_ENHANCED        8'h30
`define OFS_TX_FIFO_COUNT   8'h34
`define OFS_TX_FIFO_TRIG    8'h38
`define OFS_RX_FIFO_COUNT   8'h3C
`define OFS_RX_FIFO_TRIG    8'h40
`define OFS_RESUME_ONE      8'h44
`define OFS_RESUME_TWO      8'h48
`define OFS_PAUSE_ONE       8'h4C
`define OFS_PAUSE_TWO       8'h50
`define OFS_FLOW_STATUS     8'h54
`define OFS_TX_SEND         8'h58
`define OFS_RX_CHAR         8'h5C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SEL_TX_HI           3
`define SEL_TX_LO           2
`define SEL_RX_HI           1
`define SEL_RX_LO           0
`define ST_TX_RESUME        3
`define ST_TX_PAUSE         2
`define ST_RX_RESUME        1
`define ST_RX_PAUSE         0
`define SEND_PAUSE_BIT      0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_DIVISOR_LOW     8'h01
`define RST_INT_SOURCE      8'h01
`define RST_LINE_STATUS     8'h60
`define RST_SCRATCH         8'hFF
`define RST_ZERO            8'h00
`define RST_CHAR            8'h00

// ---------------------------------------------------------------
// timing counts (sequence gap in hclk cycles)
// ---------------------------------------------------------------
`define CHAR_GAP_CYCLES     4'h1

`endif

// ==== flow_char_match.v ====
// receive comparator: single, either-pair and two-character sequence matching
module flow_char_match (
	input wire hclk,
	input wire hresetn,
	input wire [3:0] sel,
	input wire [7:0] resume_one,
	input wire [7:0] resume_two,
	input wire [7:0] pause_one,
	input wire [7:0] pause_two,
	input wire rx_valid,
	input wire [7:0] rx_data,
	output reg got_resume,
	output reg got_pause
);
	// ---------------------------------------------------------------
	// sequence tracking
	// ---------------------------------------------------------------
	reg half_resume_q; // first resume char of a pair seen
	reg half_pause_q;  // first pause char of a pair seen
	wire [1:0] rx_sel = sel[1:0];
	wire tx_single = sel[3] ^ sel[2]; // transmit uses exactly one pair
	wire hit_r1 = rx_data == resume_one;
	wire hit_r2 = rx_data == resume_two;
	wire hit_p1 = rx_data == pause_one;
	wire hit_p2 = rx_data == pause_two;
	wire seq_mode = (rx_sel == 2'b11) && !tx_single;

	// combinational match decision per received character
	always @* begin
		got_resume = 1'b0;
		got_pause = 1'b0;
		if (rx_valid) begin
			case (rx_sel)
				2'b10: begin
					got_resume = hit_r1;
					got_pause = hit_p1;
				end
				2'b01: begin
					got_resume = hit_r2;
					got_pause = hit_p2;
				end
				2'b11: begin
					if (tx_single) begin
						got_resume = hit_r1 | hit_r2;
						got_pause = hit_p1 | hit_p2;
					end else begin
						got_resume = half_resume_q & hit_r2;
						got_pause = half_pause_q & hit_p2;
					end
				end
				default: begin
					got_resume = 1'b0;
					got_pause = 1'b0;
				end
			endcase
		end
	end

	// remember the first half of each two-character sequence
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_resume_q <= 1'b0;
			half_pause_q <= 1'b0;
		end else if (!seq_mode) begin
			half_resume_q <= 1'b0;
			half_pause_q <= 1'b0;
		end else if (rx_valid) begin
			half_resume_q <= hit_r1;
			half_pause_q <= hit_p1;
		end
	end
endmodule // flow_char_match

// ==== uart_sw_flow_control_status.v ====
// uart channel software flow control registers, sender and status
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`include "flow_ctl_consts.vh"

module uart_sw_flow_control_status (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [3:0] modem_in,
	input wire rx_char_valid,
	input wire [7:0] rx_char_data,
	output reg flow_char_valid,
	output reg [7:0] flow_char_data,
	input wire flow_char_ready,
	output reg serial_tx,
	output reg infrared_tx_out,
	output reg rts_n,
	output reg dtr_n
);
	// ---------------------------------------------------------------
	// channel registers
	// ---------------------------------------------------------------
	reg [7:0] divisor_low_q, divisor_high_q, divisor_fraction_q;
	reg [7:0] interrupt_enable_reg_q, interrupt_source_reg_q, fifo_control_reg_q;
	reg [7:0] line_control_reg_q, modem_control_reg_q, line_status_reg_q;
	reg [7:0] scratch_reg_q, feature_control_reg_q, enhanced_feature_reg_q;
	reg [7:0] tx_fifo_count_q, tx_fifo_trigger_q, rx_fifo_count_q, rx_fifo_trigger_q;
	reg [7:0] resume_char_one_q, resume_char_two_q, pause_char_one_q, pause_char_two_q;
	reg [3:0] flow_char_status_q; // indicator bits, upper bits read zero
	reg [3:0] modem_sync1_q, modem_sync2_q; // modem input synchroniser
	reg [3:0] modem_level_q; // modem status upper nibble
	reg [7:0] rx_sync1_q, rx_sync2_q; // received char synchroniser
	reg rx_v1_q, rx_v2_q, rx_v3_q; // received strobe synchroniser and edge

	// ---------------------------------------------------------------
	// bus address phase capture
	// ---------------------------------------------------------------
	reg wr_pend_q, rd_pend_q;
	reg [7:0] addr_q;
	wire take = hsel & hready & htrans[1];

	// address phase held for one data phase; zero wait states
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_pend_q <= take & hwrite;
			rd_pend_q <= take & ~hwrite;
			if (take)
				addr_q <= haddr;
		end
	end

	// ---------------------------------------------------------------
	// flow character sender
	// ---------------------------------------------------------------
	localparam S_IDLE = 3'b001;
	localparam S_FIRST = 3'b010;
	localparam S_SECOND = 3'b100;
	reg [2:0] state_q;
	reg send_pause_q; // request kind latched
	wire [3:0] sel = enhanced_feature_reg_q[3:0];
	wire [1:0] tx_sel = sel[`SEL_TX_HI:`SEL_TX_LO];
	wire send_req = wr_pend_q && addr_q == `OFS_TX_SEND;
	wire sent_done = flow_char_valid & flow_char_ready;
	wire tx_resume_evt, tx_pause_evt;

	// picks the first character of the pair chosen by tx selection
	function [7:0] first_char;
		input [1:0] ts;
		input pause;
		input [7:0] r1, r2, p1, p2;
		begin
			if (ts == 2'b01)
				first_char = pause ? p2 : r2;
			else
				first_char = pause ? p1 : r1;
		end
	endfunction

	// one or two characters per request, none with transmit select off, second only for both pairs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= S_IDLE;
			send_pause_q <= 1'b0;
			flow_char_valid <= 1'b0;
			flow_char_data <= `RST_CHAR;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (send_req && tx_sel != 2'b00) begin
						send_pause_q <= hwdata[`SEND_PAUSE_BIT];
						flow_char_valid <= 1'b1;
						flow_char_data <= first_char(tx_sel, hwdata[`SEND_PAUSE_BIT],
							resume_char_one_q, resume_char_two_q,
							pause_char_one_q, pause_char_two_q);
						state_q <= S_FIRST;
					end
				end
				S_FIRST: begin
					if (sent_done) begin
						if (tx_sel == 2'b11) begin
							flow_char_data <= send_pause_q ? pause_char_two_q :
								resume_char_two_q;
							state_q <= S_SECOND;
						end else begin
							flow_char_valid <= 1'b0;
							state_q <= S_IDLE;
						end
					end
				end
				S_SECOND: begin
					if (sent_done) begin
						flow_char_valid <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
					flow_char_valid <= 1'b0;
				end
			endcase
		end
	end

	// a transmit event is the last character of the sequence going out
	wire seq_last = sent_done & (state_q == S_SECOND | (state_q == S_FIRST & tx_sel != 2'b11));
	assign tx_resume_evt = seq_last & ~send_pause_q;
	assign tx_pause_evt = seq_last & send_pause_q;

	// ---------------------------------------------------------------
	// receive side synchronisers and comparator
	// ---------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_sync1_q <= 8'h00;
			rx_sync2_q <= 8'h00;
			rx_v1_q <= 1'b0;
			rx_v2_q <= 1'b0;
			rx_v3_q <= 1'b0;
			modem_sync1_q <= 4'h0;
			modem_sync2_q <= 4'h0;
		end else begin
			rx_sync1_q <= rx_char_data;
			rx_sync2_q <= rx_sync1_q;
			rx_v1_q <= rx_char_valid;
			rx_v2_q <= rx_v1_q;
			rx_v3_q <= rx_v2_q;
			modem_sync1_q <= modem_in;
			modem_sync2_q <= modem_sync1_q;
		end
	end

	wire rx_strobe = rx_v2_q & ~rx_v3_q; // one compare per character
	wire rx_resume_evt, rx_pause_evt;

	flow_char_match u_match (
		.hclk(hclk),
		.hresetn(hresetn),
		.sel(sel),
		.resume_one(resume_char_one_q),
		.resume_two(resume_char_two_q),
		.pause_one(pause_char_one_q),
		.pause_two(pause_char_two_q),
		.rx_valid(rx_strobe),
		.rx_data(rx_sync2_q),
		.got_resume(rx_resume_evt),
		.got_pause(rx_pause_evt)
	);

	// ---------------------------------------------------------------
	// flow status indicators
	// ---------------------------------------------------------------
	wire status_rd = rd_pend_q && addr_q == `OFS_FLOW_STATUS;
	reg [3:0] status_d;

	// events win over the read clear; last event of a kind replaces the other
	always @* begin
		status_d = status_rd ? 4'h0 : flow_char_status_q;
		if (tx_resume_evt) begin
			status_d[`ST_TX_RESUME] = 1'b1;
			status_d[`ST_TX_PAUSE] = 1'b0;
		end
		if (tx_pause_evt) begin
			status_d[`ST_TX_PAUSE] = 1'b1;
			status_d[`ST_TX_RESUME] = 1'b0;
		end
		if (rx_resume_evt) begin
			status_d[`ST_RX_RESUME] = 1'b1;
			status_d[`ST_RX_PAUSE] = 1'b0;
		end
		if (rx_pause_evt) begin
			status_d[`ST_RX_PAUSE] = 1'b1;
			status_d[`ST_RX_RESUME] = 1'b0;
		end
		if (sel == 4'h0)
			status_d = 4'h0;
	end

	// ---------------------------------------------------------------
	// register writes and reset values
	// ---------------------------------------------------------------
	wire wr = wr_pend_q;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			divisor_low_q <= `RST_DIVISOR_LOW;
			divisor_high_q <= `RST_ZERO;
			divisor_fraction_q <= `RST_ZERO;
			interrupt_enable_reg_q <= `RST_ZERO;
			interrupt_source_reg_q <= `RST_INT_SOURCE;
			fifo_control_reg_q <= `RST_ZERO;
			line_control_reg_q <= `RST_ZERO;
			modem_control_reg_q <= `RST_ZERO;
			line_status_reg_q <= `RST_LINE_STATUS;
			scratch_reg_q <= `RST_SCRATCH;
			feature_control_reg_q <= `RST_ZERO;
			enhanced_feature_reg_q <= `RST_ZERO;
			tx_fifo_count_q <= `RST_ZERO;
			tx_fifo_trigger_q <= `RST_ZERO;
			rx_fifo_count_q <= `RST_ZERO;
			rx_fifo_trigger_q <= `RST_ZERO;
			resume_char_one_q <= `RST_CHAR;
			resume_char_two_q <= `RST_CHAR;
			pause_char_one_q <= `RST_CHAR;
			pause_char_two_q <= `RST_CHAR;
			flow_char_status_q <= 4'h0;
		end else begin
			flow_char_status_q <= status_d;
			if (wr) begin
				case (addr_q)
					`OFS_DIVISOR_LOW: divisor_low_q <= hwdata[7:0];
					`OFS_DIVISOR_HIGH: divisor_high_q <= hwdata[7:0];
					`OFS_DIVISOR_FRAC: divisor_fraction_q <= hwdata[7:0];
					`OFS_INT_ENABLE: interrupt_enable_reg_q <= hwdata[7:0];
					`OFS_FIFO_CTL: fifo_control_reg_q <= hwdata[7:0];
					`OFS_LINE_CTL: line_control_reg_q <= hwdata[7:0];
					`OFS_MODEM_CTL: modem_control_reg_q <= hwdata[7:0];
					`OFS_SCRATCH: scratch_reg_q <= hwdata[7:0];
					`OFS_FEATURE_CTL: feature_control_reg_q <= hwdata[7:0];
					`OFS_ENHANCED: enhanced_feature_reg_q <= hwdata[7:0];
					`OFS_TX_FIFO_TRIG: tx_fifo_trigger_q <= hwdata[7:0];
					`OFS_RX_FIFO_TRIG: rx_fifo_trigger_q <= hwdata[7:0];
					`OFS_RESUME_ONE: resume_char_one_q <= hwdata[7:0];
					`OFS_RESUME_TWO: resume_char_two_q <= hwdata[7:0];
					`OFS_PAUSE_ONE: pause_char_one_q <= hwdata[7:0];
					`OFS_PAUSE_TWO: pause_char_two_q <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// modem status upper nibble follows synchronised inputs from release on
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			modem_level_q <= 4'h0;
		else
			modem_level_q <= modem_sync2_q;
	end

	// ---------------------------------------------------------------
	// read data, pins and response
	// ---------------------------------------------------------------
	reg [7:0] rd_d;
	always @* begin
		case (haddr)
			`OFS_DIVISOR_LOW: rd_d = divisor_low_q;
			`OFS_DIVISOR_HIGH: rd_d = divisor_high_q;
			`OFS_DIVISOR_FRAC: rd_d = divisor_fraction_q;
			`OFS_INT_ENABLE: rd_d = interrupt_enable_reg_q;
			`OFS_INT_SOURCE: rd_d = interrupt_source_reg_q;
			`OFS_FIFO_CTL: rd_d = fifo_control_reg_q;
			`OFS_LINE_CTL: rd_d = line_control_reg_q;
			`OFS_MODEM_CTL: rd_d = modem_control_reg_q;
			`OFS_LINE_STATUS: rd_d = line_status_reg_q;
			`OFS_MODEM_STATUS: rd_d = {modem_level_q, 4'h0};
			`OFS_SCRATCH: rd_d = scratch_reg_q;
			`OFS_FEATURE_CTL: rd_d = feature_control_reg_q;
			`OFS_ENHANCED: rd_d = enhanced_feature_reg_q;
			`OFS_TX_FIFO_COUNT: rd_d = tx_fifo_count_q;
			`OFS_TX_FIFO_TRIG: rd_d = tx_fifo_trigger_q;
			`OFS_RX_FIFO_COUNT: rd_d = rx_fifo_count_q;
			`OFS_RX_FIFO_TRIG: rd_d = rx_fifo_trigger_q;
			`OFS_FLOW_STATUS: rd_d = {4'h0, status_d};
			`OFS_TX_SEND: rd_d = {5'h00, state_q};
			`OFS_RX_CHAR: rd_d = rx_sync2_q;
			default: rd_d = 8'h00;
		endcase
	end

	// read data registered at the address phase edge; line pins at idle levels, rts_n and dtr_n from modem control
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			serial_tx <= 1'b1;
			infrared_tx_out <= 1'b0;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else begin
			if (take & ~hwrite)
				hrdata <= {24'h00_0000, rd_d};
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			serial_tx <= 1'b1;
			infrared_tx_out <= 1'b0;
			rts_n <= ~modem_control_reg_q[1];
			dtr_n <= ~modem_control_reg_q[0];
		end
	end
endmodule // uart_sw_flow_control_status

// ==== uart_sw_flow_control_status_asserts.sv ====
// checker of the flow control block ports
`include "flow_ctl_consts.vh"
module flow_ctl_checker (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata,
	input wire flow_char_valid,
	input wire [7:0] flow_char_data,
	input wire flow_char_ready,
	input wire serial_tx,
	input wire infrared_tx_out,
	input wire rts_n,
	input wire dtr_n
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// helper mirror of the select bits
	// ----------------------------------------
	wire take = hsel && hready && htrans[1]; // address phase accepted
	wire rd_take = take && !hwrite; // read accepted
	reg wr_sel_q; // select write in data phase
	reg wr_send_q; // send command in data phase
	reg [3:0] sel_q; // select bits as last written
	// track select writes and send commands at their data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_sel_q <= 1'b0;
			wr_send_q <= 1'b0;
			sel_q <= 4'h0;
		end else begin
			wr_sel_q <= take && hwrite && haddr == `OFS_ENHANCED;
			wr_send_q <= take && hwrite && haddr == `OFS_TX_SEND;
			if (wr_sel_q) begin
				sel_q <= hwdata[3:0];
			end
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_RESET_PINS: assert property ($rose(hresetn) |->
		serial_tx && !infrared_tx_out && rts_n && dtr_n && !flow_char_valid)
		else $error("pins not at reset levels");
	AST_IDLE_LINE: assert property (serial_tx && !infrared_tx_out)
		else $error("serial or infrared line left idle level");
	AST_NO_TX_SEL: assert property (sel_q[3:2] == 2'b00 |-> !$rose(flow_char_valid))
		else $error("flow char offered with transmit select off");
	AST_OFF_STATUS: assert property (rd_take && haddr == `OFS_FLOW_STATUS
		&& sel_q == 4'h0 |=> hrdata[7:0] == 8'h00)
		else $error("status not zero while disabled");
	AST_RSVD_BITS: assert property (rd_take && haddr == `OFS_FLOW_STATUS
		|=> hrdata[7:4] == 4'h0)
		else $error("status upper bits not zero");
	AST_WO_READ: assert property (rd_take && haddr >= `OFS_RESUME_ONE
		&& haddr <= `OFS_PAUSE_TWO |=> hrdata == 32'h0000_0000)
		else $error("write-only char register read nonzero");
	AST_HOLD_CHAR: assert property (flow_char_valid && !flow_char_ready
		|=> flow_char_valid && $stable(flow_char_data))
		else $error("flow char dropped before accepted");
	AST_SEND_LATE: assert property (wr_send_q && sel_q[3:2] != 2'b00
		&& !flow_char_valid |-> ##[1:2] flow_char_valid)
		else $error("send command produced no flow char");
endmodule // flow_ctl_checker

// ==== flow_peer_model.sv ====
// remote serial party: takes flow chars, sends received chars
module flow_peer_model (
	input wire hclk,
	input wire hresetn,
	input wire [3:0] stall,
	input wire flow_char_valid,
	input wire [7:0] flow_char_data,
	output reg flow_char_ready,
	output reg rx_char_valid,
	output reg [7:0] rx_char_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$]; // chars taken from the block
	reg [3:0] wait_q; // cycles stalled so far
	initial begin
		rx_char_valid = 1'b0;
		rx_char_data = 8'h00;
	end
	// accept each offered char after the chosen stall
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flow_char_ready <= 1'b0;
			wait_q <= 4'h0;
		end else begin
			flow_char_ready <= 1'b0;
			if (flow_char_valid && flow_char_ready) begin
				got.push_back(flow_char_data);
				wait_q <= 4'h0;
			end else if (flow_char_valid) begin
				if (wait_q >= stall) begin
					flow_char_ready <= 1'b1;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
	// one received char: data held well past the compare point
	task send_char(input logic [7:0] c);
		@(posedge hclk);
		rx_char_valid <= 1'b1;
		rx_char_data <= c;
		repeat (6) @(posedge hclk);
		rx_char_valid <= 1'b0;
		rx_char_data <= ~c; // released data shows no stale value
		repeat (6) @(posedge hclk);
	endtask
endmodule // flow_peer_model

// ==== test_uart_sw_flow_control_status.sv ====
// testbench of the flow control block
`include "flow_ctl_consts.vh"
module test_uart_sw_flow_control_status;
	timeunit 1ns;
	timeprecision 1ns;
	reg hclk, hresetn, hsel, hwrite;
	reg [7:0] haddr;
	reg [1:0] htrans;
	reg [2:0] hsize;
	reg [31:0] hwdata;
	reg [3:0] modem_in, stall;
	wire hready, hreadyout, hresp, flow_char_valid, flow_char_ready, rx_char_valid;
	wire serial_tx, infrared_tx_out, rts_n, dtr_n;
	wire [31:0] hrdata;
	wire [7:0] flow_char_data, rx_char_data;
	integer err_count, checks_done, i, j, k, ne;
	reg [31:0] rd;
	reg [7:0] ch[4] = '{8'h11, 8'h12, 8'h13, 8'h14}; // resume 1,2 then pause 1,2
	reg [7:0] ca[4] = '{`OFS_RESUME_ONE, `OFS_RESUME_TWO, `OFS_PAUSE_ONE, `OFS_PAUSE_TWO};
	reg [7:0] ra[22] = '{`OFS_DIVISOR_LOW, `OFS_DIVISOR_HIGH, `OFS_DIVISOR_FRAC,
		`OFS_INT_ENABLE, `OFS_INT_SOURCE, `OFS_FIFO_CTL, `OFS_LINE_CTL, `OFS_MODEM_CTL,
		`OFS_LINE_STATUS, `OFS_SCRATCH, `OFS_FEATURE_CTL, `OFS_ENHANCED, `OFS_TX_FIFO_COUNT,
		`OFS_TX_FIFO_TRIG, `OFS_RX_FIFO_COUNT, `OFS_RX_FIFO_TRIG, `OFS_RESUME_ONE,
		`OFS_RESUME_TWO, `OFS_PAUSE_ONE, `OFS_PAUSE_TWO, `OFS_FLOW_STATUS, 8'hFC};
	reg [7:0] re[22] = '{`RST_DIVISOR_LOW, 0, 0, 0, `RST_INT_SOURCE, 0, 0, 0,
		`RST_LINE_STATUS, `RST_SCRATCH, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
	// receive cases: select, first char index, second index (4 = none), status
	reg [3:0] sv[8] = '{4'h0, 4'h2, 4'h1, 4'hB, 4'h7, 4'hF, 4'h3, 4'hF};
	integer c0[8] = '{2, 3, 0, 1, 2, 2, 0, 3};
	integer c1[8] = '{4, 0, 3, 4, 4, 3, 1, 2};
	reg [7:0] ex[8] = '{8'h00, 8'h02, 8'h01, 8'h02, 8'h01, 8'h01, 8'h02, 8'h00};
	assign hready = hreadyout;
	// clock at 10 MHz
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	uart_sw_flow_control_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.modem_in(modem_in), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.flow_char_valid(flow_char_valid), .flow_char_data(flow_char_data),
		.flow_char_ready(flow_char_ready), .serial_tx(serial_tx),
		.infrared_tx_out(infrared_tx_out), .rts_n(rts_n), .dtr_n(dtr_n));
	flow_peer_model model (.hclk(hclk), .hresetn(hresetn), .stall(stall),
		.flow_char_valid(flow_char_valid), .flow_char_data(flow_char_data),
		.flow_char_ready(flow_char_ready), .rx_char_valid(rx_char_valid),
		.rx_char_data(rx_char_data));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// bounded wait for hready at a rising edge
	task wait_ready;
		integer n;
		n = 0;
		do begin
			@(posedge hclk);
			n = n + 1;
		end while (hready !== 1'b1 && n < 40);
		if (hready !== 1'b1) begin
			err_count = err_count + 1;
			wrap_up;
		end
	endtask
	// one single word transfer: address phase, then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		wait_ready;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		wait_ready;
		rd = hrdata;
	endtask
	// clear the select bits before any new setting
	task set_sel(input logic [3:0] v);
		bus(1'b1, `OFS_ENHANCED, 32'h0000_0000);
		bus(1'b1, `OFS_ENHANCED, 32'(v));
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{hsel, hwrite, haddr, htrans, hsize, hwdata, stall} = '0;
		modem_in = 4'hA;
		hresetn = 1'b0;
		err_count = 0;
		checks_done = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check("reset pins", 32'({serial_tx, infrared_tx_out, rts_n, dtr_n}), 32'hB);
		for (i = 0; i < 22; i++) begin
			bus(1'b0, ra[i], 32'h0000_0000);
			check("reset value", rd, 32'(re[i]));
		end
		bus(1'b0, `OFS_MODEM_STATUS, 32'h0000_0000);
		check("modem status", rd, 32'({modem_in, 4'h0}));
		for (i = 0; i < 4; i++) begin
			bus(1'b1, ca[i], 32'(ch[i]));
			bus(1'b0, ca[i], 32'h0000_0000);
			check("char reg read", rd, 32'h0000_0000);
		end
		// each transmit selection, pause then resume, partner stalling
		for (i = 0; i < 4; i++) begin
			set_sel(4'(i << 2));
			stall <= 4'(i);
			ne = (i == 0) ? 0 : ((i == 3) ? 2 : 1);
			for (k = 0; k < 2; k++) begin
				model.got.delete();
				bus(1'b1, `OFS_TX_SEND, 32'(k == 0));
				for (j = 0; j < 40 && model.got.size() < ne; j++) @(posedge hclk);
				// a sender that never finishes ends the run as a mismatch
				if (model.got.size() < ne) begin
					err_count = err_count + 1;
					wrap_up;
				end
				repeat (4) @(posedge hclk);
				check("sent count", 32'(model.got.size()), 32'(ne));
				for (j = 0; j < ne; j++) begin
					check("sent char", 32'(model.got[j]), 32'(ch[(k == 0 ? 2 : 0) + (i == 1 ? 1 : j)]));
				end
				bus(1'b0, `OFS_FLOW_STATUS, 32'h0000_0000);
				check("tx status", rd, (i == 0) ? 0 : ((k == 0) ? 32'h4 : 32'h8));
			end
		end
		// receive comparisons for every receive selection
		for (i = 0; i < 8; i++) begin
			set_sel(sv[i]);
			model.send_char(ch[c0[i]]);
			if (c1[i] < 4) model.send_char(ch[c1[i]]);
			bus(1'b0, `OFS_FLOW_STATUS, 32'h0000_0000);
			check("rx status", rd, 32'(ex[i]));
		end
		// disabling clears a pending indication
		set_sel(4'h2);
		model.send_char(ch[2]);
		bus(1'b1, `OFS_ENHANCED, 32'h0000_0000);
		bus(1'b0, `OFS_FLOW_STATUS, 32'h0000_0000);
		check("status after disable", rd, 32'h0000_0000);
		wrap_up;
	end
endmodule // test_uart_sw_flow_control_status
bind uart_sw_flow_control_status flow_ctl_checker chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .flow_char_valid(flow_char_valid),
	.flow_char_data(flow_char_data), .flow_char_ready(flow_char_ready),
	.serial_tx(serial_tx), .infrared_tx_out(infrared_tx_out), .rts_n(rts_n), .dtr_n(dtr_n));
